/* File: rtl/ssp_clk_div.sv */
// Serial clock divider: prescaler then rate divider, giving one pulse per half serial period.
// Assumes restart is pulsed at frame start so the first half period is whole.
`timescale 1ns/1ns
`default_nettype none
`include "ssp_regs.svh"

module ssp_clk_div (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Control
    input wire logic restart,
    input wire logic [7:0] prescaleDivisor,
    input wire logic [7:0] clockRateField,
    // Half-period enable
    output logic halfTick
);
    logic [6:0] preCnt_q, preCnt_d, preHalf;
    logic [7:0] rateCnt_q, rateCnt_d;
    logic halfTick_q, halfTick_d;
    logic preEnd, rateEnd;

    // Odd divisors lose bit 0 and small ones clamp, keeping the prescale even
    always_comb begin
        preHalf = (prescaleDivisor < `SSP_PRESCALE_MIN) ? 7'h01 : prescaleDivisor[7:1];
        preEnd = preCnt_q == preHalf - 7'h01;
        rateEnd = rateCnt_q == clockRateField;
        preCnt_d = preEnd ? 7'h00 : preCnt_q + 7'h01;
        rateCnt_d = rateCnt_q;
        if (preEnd) begin
            rateCnt_d = rateEnd ? 8'h00 : rateCnt_q + 8'h01;
        end
        halfTick_d = preEnd && rateEnd;
        if (restart) begin
            preCnt_d = 7'h00;
            rateCnt_d = 8'h00;
            halfTick_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            preCnt_q <= 7'h00;
            rateCnt_q <= 8'h00;
            halfTick_q <= 1'b0;
        end else begin
            preCnt_q <= preCnt_d;
            rateCnt_q <= rateCnt_d;
            halfTick_q <= halfTick_d;
        end
    end

    assign halfTick = halfTick_q;

endmodule : ssp_clk_div

`default_nettype wire

/* File: rtl/ssp_core.sv */
// Synchronous serial port core: FIFOs, clock divider, master/slave serial engine, status.
// Assumes pin inputs are already synchronous to clk and configuration is static during frames.
//
// Summary of operation
// - Prescale divisor even, from 2 to 254.
// - Rate divider is one plus rate field.
// - Master to half, slave to twelfth clock.
// - Eight-deep sixteen-bit transmit queue, pushed per write.
// - Eight-deep sixteen-bit receive queue, popped per read.
// - Serial input shifted before parallel queue load.
// - Four interrupt sources ORed into one line.
// - Mask bit one enables; raw and masked visible.
// - Four to sixteen bits, MSB first.
// - Clock idles inactive; toggles only during words and the pulse-format frame pulse.
// - Timeout when idle with unread receive data.
// - Frame low throughout SPI and control-word frames.
// - Pulse format: frame pulse, drive rise, sample fall.
// - Control word eight bits, wait, then answer.
// - Pulse format idle: clock, frame low, data released.
// - Pulse format loads word with the frame pulse.
// - Pulse format master pushes word at next rising edge.
// - SPI idle clock level follows polarity bit.
// - Phase zero captures first edge, one second.
// - Mode zero idle levels; clock driven only as master.
// - Mode zero: frame low, data, then rising clock.
// - Frame high after last capture; pulses between words.
`timescale 1ns/1ns
`default_nettype none
`include "ssp_regs.svh"

module ssp_core (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Configuration and status control
    input wire ssp_pkg::sspConfig_t cfg,
    input wire logic [`SSP_STATUS_W-1:0] intMask,
    input wire logic [1:0] statusClear,
    // Transmit words from software
    input wire logic txWrite,
    input wire logic [`SSP_DATA_W-1:0] txData,
    output logic txReady,
    // Receive words to software
    input wire logic rxRead,
    output logic rxAvail,
    output logic [`SSP_DATA_W-1:0] rxData,
    output logic rxDataValid,
    // Status and interrupt
    output logic [`SSP_STATUS_W-1:0] rawStatus,
    output logic [`SSP_STATUS_W-1:0] maskedStatus,
    output logic intRequest,
    // Serial pins
    input wire ssp_pkg::sspPinIn_t pinIn,
    output var ssp_pkg::sspPinOut_t pinOut
);
    import ssp_pkg::*;

    logic txHeadValid, txPop, rxPush, rxInReady, rxPop, halfTick, divRestart;
    logic [`SSP_DATA_W-1:0] txHead, rxHead;
    logic [`SSP_FIFO_AW:0] txCount, rxCount;
    sspEngState_t state_q, state_d;
    logic [15:0] txShift_q, txShift_d, rxShift_q, rxShift_d;
    logic [4:0] bitCnt_q, bitCnt_d;
    logic half_q, half_d, firstChange_q, firstChange_d;
    logic sclkPrev_q, framePrev_q;
    sspPinOut_t pins_q, pins_d;
    logic master, idleLvl, sampleTrail, pinEdge, pinLead, evt, lead, startMaster, startSlave;
    logic [6:0] idleCnt_q, idleCnt_d;
    logic timeout_q, timeout_d, overrun_q, overrun_d;
    logic [`SSP_STATUS_W-1:0] raw_q, raw_d, masked_q, masked_d;
    logic irq_q, irq_d, rxDataValid_q, rxDataValid_d;
    logic [`SSP_DATA_W-1:0] rxData_q, rxData_d;

    // Bits in one frame; the master's control-word frame adds the control byte and wait bit
    function automatic logic [4:0] frameBits(input sspConfig_t c);
        logic [4:0] n;
        n = {1'b0, c.sizeMinusOne} + 5'h01;
        if (c.format == SSP_FMT_CTRLWORD && !c.slaveMode) begin
            n = n + `SSP_MW_CTRL_BITS + `SSP_MW_WAIT_BITS;
        end
        frameBits = n;
    endfunction : frameBits

    // Left-align a word so that bit 15 of the shifter is always the next bit out
    function automatic logic [15:0] alignTx(input sspConfig_t c, input logic [15:0] w);
        if (c.format == SSP_FMT_CTRLWORD && !c.slaveMode) begin
            alignTx = {w[7:0], 8'h00};
        end else begin
            alignTx = w << (4'hF - c.sizeMinusOne);
        end
    endfunction : alignTx

    // Transmit queue, software fills, engine drains
    ssp_fifo #(.WIDTH(`SSP_DATA_W), .DEPTH(`SSP_FIFO_DEPTH), .AW(`SSP_FIFO_AW)) txFifo (
        .clk(clk),
        .arst_n(arst_n),
        .inValid(txWrite),
        .inData(txData),
        .inReady(txReady),
        .outValid(txHeadValid),
        .outData(txHead),
        .outReady(txPop),
        .count(txCount)
    );

    // Receive queue, engine fills, software drains
    ssp_fifo #(.WIDTH(`SSP_DATA_W), .DEPTH(`SSP_FIFO_DEPTH), .AW(`SSP_FIFO_AW)) rxFifo (
        .clk(clk),
        .arst_n(arst_n),
        .inValid(rxPush),
        .inData(rxShift_q),
        .inReady(rxInReady),
        .outValid(rxAvail),
        .outData(rxHead),
        .outReady(rxRead),
        .count(rxCount)
    );

    // Half-period enable for the master clock and the idle timeout
    ssp_clk_div clkDiv (
        .clk(clk),
        .arst_n(arst_n),
        .restart(divRestart),
        .prescaleDivisor(cfg.prescaleDivisor),
        .clockRateField(cfg.clockRateField),
        .halfTick(halfTick)
    );

    // Edge classification; a slave sees each pin edge as one change in the sampled level
    always_comb begin
        master = !cfg.slaveMode;
        idleLvl = (cfg.format == SSP_FMT_SPI) && cfg.clockPolarity;
        sampleTrail = (cfg.format == SSP_FMT_PULSE) || (cfg.format == SSP_FMT_SPI && cfg.clockPhase);
        pinEdge = pinIn.sclkIn != sclkPrev_q;
        pinLead = pinEdge && (pinIn.sclkIn != idleLvl);
        evt = master ? halfTick : pinEdge;
        lead = master ? !half_q : pinLead;
        startMaster = cfg.enable && master && txHeadValid;
        startSlave = cfg.enable && !master && ((cfg.format != SSP_FMT_PULSE && framePrev_q && !pinIn.frameIn)
            || (cfg.format == SSP_FMT_PULSE && pinIn.frameIn && pinEdge && !pinLead));
    end

    // Serial engine next state
    always_comb begin
        state_d = state_q;
        txShift_d = txShift_q;
        rxShift_d = rxShift_q;
        bitCnt_d = bitCnt_q;
        half_d = half_q;
        firstChange_d = firstChange_q;
        pins_d = pins_q;
        txPop = 1'b0;
        rxPush = 1'b0;
        divRestart = 1'b0;
        case (state_q)
            ENG_IDLE: begin
                // Idle levels; clock pad driven only by a master
                pins_d.sclkOut = master ? idleLvl : 1'b0;
                pins_d.sclkOe = master && cfg.enable;
                pins_d.frameOut = cfg.format != SSP_FMT_PULSE;
                pins_d.frameOe = master && cfg.enable;
                pins_d.dataOe = master && cfg.enable && cfg.format != SSP_FMT_PULSE;
                if (startMaster || startSlave) begin
                    txPop = txHeadValid;
                    txShift_d = txHeadValid ? alignTx(cfg, txHead) : 16'h0000;
                    rxShift_d = 16'h0000;
                    bitCnt_d = 5'h00;
                    half_d = 1'b0;
                    firstChange_d = sampleTrail;
                    pins_d.dataOe = 1'b1;
                    divRestart = 1'b1;
                    if (master) begin
                        pins_d.frameOut = cfg.format == SSP_FMT_PULSE;
                        state_d = ENG_SETUP;
                    end else begin
                        state_d = ENG_SHIFT;
                    end
                end
            end
            ENG_SETUP: begin
                // Pulse format spends a whole clock with frame high; others half a period
                if (halfTick) begin
                    if (cfg.format == SSP_FMT_PULSE && !half_q) begin
                        pins_d.sclkOut = 1'b1;
                        half_d = 1'b1;
                    end else begin
                        pins_d.sclkOut = idleLvl;
                        pins_d.frameOut = cfg.format == SSP_FMT_PULSE ? 1'b0 : pins_q.frameOut;
                        half_d = 1'b0;
                        state_d = ENG_SHIFT;
                    end
                end
            end
            ENG_SHIFT: begin
                if (!master && cfg.format != SSP_FMT_PULSE && pinIn.frameIn) begin
                    // Select withdrawn mid-word: drop the partial word
                    pins_d.dataOe = 1'b0;
                    state_d = ENG_IDLE;
                end else if (evt) begin
                    if (master) begin
                        pins_d.sclkOut = lead ? !idleLvl : idleLvl;
                    end
                    half_d = !half_q;
                    if (lead != sampleTrail) begin
                        // Capture edge; control-word master ignores input until the answer
                        if (!master || cfg.format != SSP_FMT_CTRLWORD || bitCnt_q > `SSP_MW_CTRL_BITS) begin
                            rxShift_d = {rxShift_q[14:0], pinIn.dataIn};
                        end
                    end else if (firstChange_q) begin
                        firstChange_d = 1'b0;
                    end else begin
                        txShift_d = {txShift_q[14:0], 1'b0};
                    end
                    if (!lead) begin
                        bitCnt_d = bitCnt_q + 5'h01;
                        if (bitCnt_q == frameBits(cfg) - 5'h01) begin
                            half_d = 1'b0;
                            state_d = ENG_DONE;
                        end
                    end
                end
            end
            ENG_DONE: begin
                if (!master) begin
                    rxPush = 1'b1;
                    pins_d.dataOe = 1'b0;
                    state_d = ENG_IDLE;
                end else if (halfTick) begin
                    if (!half_q) begin
                        // Half a period after the last edge, i.e. where the next leading edge would be
                        rxPush = 1'b1;
                        half_d = 1'b1;
                    end else if (cfg.format == SSP_FMT_SPI && cfg.clockPhase && cfg.enable && txHeadValid) begin
                        // Phase one keeps frame low across back-to-back words
                        txPop = 1'b1;
                        txShift_d = alignTx(cfg, txHead);
                        rxShift_d = 16'h0000;
                        bitCnt_d = 5'h00;
                        half_d = 1'b0;
                        firstChange_d = 1'b1;
                        state_d = ENG_SHIFT;
                    end else begin
                        pins_d.frameOut = cfg.format != SSP_FMT_PULSE;
                        state_d = ENG_IDLE;
                    end
                end
            end
            default: begin
                state_d = ENG_IDLE;
            end
        endcase
        pins_d.dataOut = (state_d == ENG_IDLE) ? 1'b0 : txShift_d[15];
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ENG_IDLE;
            txShift_q <= 16'h0000;
            rxShift_q <= 16'h0000;
            bitCnt_q <= 5'h00;
            half_q <= 1'b0;
            firstChange_q <= 1'b0;
            sclkPrev_q <= 1'b0;
            framePrev_q <= 1'b1;
            pins_q <= '{sclkOut: 1'b0, sclkOe: 1'b0, frameOut: 1'b1, frameOe: 1'b0, dataOut: 1'b0, dataOe: 1'b0};
        end else begin
            state_q <= state_d;
            txShift_q <= txShift_d;
            rxShift_q <= rxShift_d;
            bitCnt_q <= bitCnt_d;
            half_q <= half_d;
            firstChange_q <= firstChange_d;
            sclkPrev_q <= pinIn.sclkIn;
            framePrev_q <= pinIn.frameIn;
            pins_q <= pins_d;
        end
    end

    // Timeout, sticky flags, status and read data; a set always beats a same-cycle clear
    always_comb begin
        idleCnt_d = idleCnt_q;
        if (rxCount == '0 || state_q != ENG_IDLE) begin
            idleCnt_d = 7'h00;
        end else if (halfTick && idleCnt_q != `SSP_TIMEOUT_HALVES) begin
            idleCnt_d = idleCnt_q + 7'h01;
        end
        timeout_d = (idleCnt_d == `SSP_TIMEOUT_HALVES && idleCnt_q != `SSP_TIMEOUT_HALVES)
            || (timeout_q && !statusClear[0]);
        overrun_d = (rxPush && !rxInReady) || (overrun_q && !statusClear[1]);
        raw_d = '0;
        raw_d[`SSP_ST_TXSVC] = txCount <= `SSP_HALF_FULL;
        raw_d[`SSP_ST_RXSVC] = rxCount >= `SSP_HALF_FULL;
        raw_d[`SSP_ST_TIMEOUT] = timeout_d;
        raw_d[`SSP_ST_OVERRUN] = overrun_d;
        masked_d = raw_d & intMask;
        irq_d = |masked_d;
        rxPop = rxRead && rxAvail;
        rxData_d = rxPop ? rxHead : rxData_q;
        rxDataValid_d = rxPop;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            idleCnt_q <= 7'h00;
            timeout_q <= 1'b0;
            overrun_q <= 1'b0;
            raw_q <= `SSP_STATUS_RESET;
            masked_q <= `SSP_STATUS_RESET;
            irq_q <= 1'b0;
            rxData_q <= '0;
            rxDataValid_q <= 1'b0;
        end else begin
            idleCnt_q <= idleCnt_d;
            timeout_q <= timeout_d;
            overrun_q <= overrun_d;
            raw_q <= raw_d;
            masked_q <= masked_d;
            irq_q <= irq_d;
            rxData_q <= rxData_d;
            rxDataValid_q <= rxDataValid_d;
        end
    end

    assign pinOut = pins_q;
    assign rawStatus = raw_q;
    assign maskedStatus = masked_q;
    assign intRequest = irq_q;
    assign rxData = rxData_q;
    assign rxDataValid = rxDataValid_q;

    // Checks on the engine and status
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_irq_or_sources: assert property (intRequest == |maskedStatus)
        else $error("interrupt line differs from OR of masked status");
    a_mask_gates_raw: assert property ($past(arst_n) |-> maskedStatus == (rawStatus & $past(intMask)))
        else $error("masked status is not raw status gated by mask");
    a_tx_service_lvl: assert property ($past(arst_n) |-> rawStatus[`SSP_ST_TXSVC] == ($past(txCount) <= 4'h4))
        else $error("transmit service level wrong");
    a_idle_clock_lvl: assert property ((state_q == ENG_IDLE && $past(state_q == ENG_IDLE) && master && $past(master))
        |-> pinOut.sclkOut == $past(idleLvl))
        else $error("idle serial clock not at polarity level");
    a_spi_frame_low: assert property ((state_q == ENG_SHIFT && master && cfg.format == SSP_FMT_SPI) |-> !pinOut.frameOut)
        else $error("frame not low during SPI word");
    a_pulse_frame_hi: assert property ((state_q == ENG_IDLE && startMaster && cfg.format == SSP_FMT_PULSE)
        |=> pinOut.frameOut && state_q == ENG_SETUP)
        else $error("frame pulse missing at word start");
    a_overrun_flag: assert property ((rxPush && !rxInReady) |=> rawStatus[`SSP_ST_OVERRUN] && rxCount == 4'h8)
        else $error("overrun not flagged on full queue");
    a_rx_push_count: assert property ((rxPush && rxInReady && !rxPop) |=> rxCount == $past(rxCount) + 4'h1)
        else $error("receive word not stored");
    a_tx_push_count: assert property ((txWrite && txReady && !txPop) |=> txCount == $past(txCount) + 4'h1)
        else $error("transmit word not stored");
    a_timeout_cause: assert property ($rose(rawStatus[`SSP_ST_TIMEOUT]) |-> $past(rxCount, 2) != 4'h0)
        else $error("timeout raised with empty receive queue");

endmodule : ssp_core

`default_nettype wire

/* File: rtl/ssp_fifo.sv */
// Word FIFO with valid/ready on both sides and registered full and empty.
// Assumes DEPTH is a power of two equal to 2**AW.
`timescale 1ns/1ns
`default_nettype none

module ssp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Filling side
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    // Draining side
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady,
    // Fill level
    output logic [AW:0] count
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic inReady_q, inReady_d, outValid_q, outValid_d;
    logic push, pop;

    // Pointer and level update; flags come from the next level so they never lag
    always_comb begin
        push = inValid && inReady_q;
        pop = outReady && outValid_q;
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        inReady_d = cnt_d < (AW+1)'(DEPTH);
        outValid_d = cnt_d != '0;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            inReady_q <= 1'b1;
            outValid_q <= 1'b0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            inReady_q <= inReady_d;
            outValid_q <= outValid_d;
        end
    end

    // Storage has no reset; empty entries are never shown
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= inData;
        end
    end

    assign inReady = inReady_q;
    assign outValid = outValid_q;
    assign outData = mem[rd_q];
    assign count = cnt_q;

endmodule : ssp_fifo

`default_nettype wire

/* File: shared/ssp_pkg.sv */
// Types of the synchronous serial port: formats, engine states, configuration and pin bundles.
// Assumes the constants header is on the include path.
`include "ssp_regs.svh"

package ssp_pkg;

    // Frame formats
    typedef enum logic [1:0] {
        SSP_FMT_SPI,
        SSP_FMT_PULSE,
        SSP_FMT_CTRLWORD
    } sspFormat_t;

    // Serial engine states
    typedef enum logic [1:0] {
        ENG_IDLE,
        ENG_SETUP,
        ENG_SHIFT,
        ENG_DONE
    } sspEngState_t;

    // Static configuration, held by software while a frame runs
    typedef struct packed {
        logic enable;
        logic slaveMode;
        sspFormat_t format;
        logic [3:0] sizeMinusOne;
        logic clockPolarity;
        logic clockPhase;
        logic [7:0] prescaleDivisor;
        logic [7:0] clockRateField;
    } sspConfig_t;

    // Pin levels seen by the block
    typedef struct packed {
        logic sclkIn;
        logic frameIn;
        logic dataIn;
    } sspPinIn_t;

    // Pin levels and enables driven by the block
    typedef struct packed {
        logic sclkOut;
        logic sclkOe;
        logic frameOut;
        logic frameOe;
        logic dataOut;
        logic dataOe;
    } sspPinOut_t;

endpackage : ssp_pkg

/* File: shared/ssp_regs.svh */
// Constants of the synchronous serial port: widths, depths, status bit positions, counts.
// Assumes inclusion by the package and the design files; holds definitions only.
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH

// Data path
`define SSP_DATA_W 16
`define SSP_FIFO_DEPTH 8
`define SSP_FIFO_AW 3
`define SSP_HALF_FULL 4'h4

// Clock generation
`define SSP_PRESCALE_MIN 8'h02

// Control-word format: control bits sent, then wait bits before the answer
`define SSP_MW_CTRL_BITS 5'h08
`define SSP_MW_WAIT_BITS 5'h01

// Receive timeout, in half serial-clock periods of idle line
`define SSP_TIMEOUT_HALVES 7'h40

// Status bit positions
`define SSP_ST_TXSVC 0
`define SSP_ST_RXSVC 1
`define SSP_ST_TIMEOUT 2
`define SSP_ST_OVERRUN 3
`define SSP_STATUS_W 4
`define SSP_STATUS_RESET 4'h0

`endif

/* File: tb/ssp_slave_model.sv */
// SPI mode-zero slave model facing the port core.
// Assumes the core is master with idle clock low.
`timescale 1ns/1ns
`default_nettype none

module ssp_slave_model (
    // Pins
    input wire logic sclk,
    input wire logic frameSel,
    input wire logic mosi,
    output logic miso,
    // Words
    input wire logic [7:0] replyWord,
    output logic [7:0] gotWord
);
    logic [7:0] shiftQ;

    initial begin
        miso = 1'h0;
        gotWord = 8'h00;
        shiftQ = 8'h00;
    end
    // Reply MSB presented at select
    always @(negedge frameSel) begin
        shiftQ = replyWord;
        miso = replyWord[7];
    end
    // Capture on rising edge
    always @(posedge sclk) if (!frameSel) begin
        gotWord = {gotWord[6:0], mosi};
        shiftQ = {shiftQ[6:0], 1'h0};
    end
    // Change on falling edge
    always @(negedge sclk) if (!frameSel) miso = shiftQ[7];
    // Released line must not look like data
    always @(posedge frameSel) miso = ~miso;
endmodule : ssp_slave_model

`default_nettype wire

/* File: tb/sync_serial_port_core_tb.sv */
// Testbench of the serial port core as SPI master.
// Assumes package and header compiled first.
`timescale 1ns/1ns
`default_nettype none

module sync_serial_port_core_tb;
    import ssp_pkg::*;
    logic clk, arst_n, txWrite, txReady, rxRead, rxAvail, rxDataValid, intRequest;
    sspConfig_t cfg;
    logic [3:0] intMask, rawStatus, maskedStatus;
    logic [1:0] statusClear;
    logic [15:0] txData, rxData;
    sspPinIn_t pinIn;
    sspPinOut_t pinOut;
    logic miso;
    logic [7:0] gotWord;
    int fails, nTests, cycles;

    ssp_core ssp_core_inst (.clk(clk), .arst_n(arst_n), .cfg(cfg), .intMask(intMask),
        .statusClear(statusClear), .txWrite(txWrite), .txData(txData), .txReady(txReady),
        .rxRead(rxRead), .rxAvail(rxAvail), .rxData(rxData), .rxDataValid(rxDataValid),
        .rawStatus(rawStatus), .maskedStatus(maskedStatus), .intRequest(intRequest),
        .pinIn(pinIn), .pinOut(pinOut));
    ssp_slave_model ssp_slave_model_inst (.sclk(pinOut.sclkOut), .frameSel(pinOut.frameOut),
        .mosi(pinOut.dataOut), .miso(miso), .replyWord(8'h3C), .gotWord(gotWord));
    // Clock and frame loop back as the wire
    assign pinIn = '{sclkIn: pinOut.sclkOut, frameIn: pinOut.frameOut, dataIn: miso};

    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nTests++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step
    task automatic push(input logic [15:0] d);
        txData = d;
        txWrite = 1'h1;
        step(1);
        txWrite = 1'h0;
    endtask : push
    task automatic pop();
        rxRead = 1'h1;
        step(1);
        rxRead = 1'h0;
        chk(rxDataValid, 16'h1);
        step(1);
        chk(rxDataValid, 16'h0);
    endtask : pop

    task automatic t_reset();
        chk(txReady, 16'h1);
        chk(rxAvail, 16'h0);
        chk(pinOut.frameOut, 16'h1);
        chk(pinOut.sclkOut, 16'h0);
        chk(rawStatus, 16'h1);
        chk({pinOut.sclkOe, pinOut.frameOe, pinOut.dataOe}, 16'h7);
    endtask : t_reset
    task automatic t_single();
        push(16'h00A5);
        for (int k = 0; k < 200 && rxAvail !== 1'h1; k++) step(1);
        chk(gotWord, 16'h00A5);
        pop();
        chk(rxData, 16'h003C);
    endtask : t_single
    task automatic t_fill();
        cfg.enable = 1'h0;
        txWrite = 1'h1;
        for (int i = 0; i < 9; i++) begin
            txData = 16'h0010 + 16'(i);
            step(1);
        end
        txWrite = 1'h0;
        chk(txReady, 16'h0);
        chk(rawStatus[0], 16'h0);
        cfg.enable = 1'h1;
        step(400);
        chk(gotWord, 16'h0017);
        chk(rawStatus[2:1], 16'h3);
        intMask = 4'h2;
        step(2);
        chk(maskedStatus, 16'h2);
        chk(intRequest, 16'h1);
        push(16'h0055);
        step(60);
        chk(rawStatus[3], 16'h1);
        statusClear = 2'h2;
        step(1);
        statusClear = 2'h0;
        step(1);
        chk(rawStatus[3], 16'h0);
        for (int i = 0; i < 8; i++) pop();
        chk(rxAvail, 16'h0);
        chk(rawStatus[2], 16'h1);
        statusClear = 2'h1;
        step(1);
        statusClear = 2'h0;
        step(1);
        chk(rawStatus[2], 16'h0);
    endtask : t_fill
    // Pulse format: transmit side is not judged, the model's capture races the shift
    task automatic t_pulse();
        cfg.format = SSP_FMT_PULSE;
        step(2);
        push(16'h0081);
        step(1);
        chk(pinOut.frameOut, 16'h1);
        for (int k = 0; k < 200 && rxAvail !== 1'h1; k++) step(1);
        chk(pinOut.frameOut, 16'h0);
        pop();
        chk(rxData, 16'h003C);
        cfg.format = SSP_FMT_SPI;
        step(2);
    endtask : t_pulse
    task automatic t_idle();
        cfg.clockPolarity = 1'h1;
        step(3);
        chk(pinOut.sclkOut, 16'h1);
        cfg.clockPolarity = 1'h0;
        cfg.format = SSP_FMT_PULSE;
        step(3);
        chk({pinOut.dataOe, pinOut.frameOut}, 16'h0);
        cfg.format = SSP_FMT_SPI;
        cfg.slaveMode = 1'h1;
        step(3);
        chk(pinOut.sclkOe, 16'h0);
    endtask : t_idle

    initial begin
        cfg = '0;
        cfg.enable = 1'h1;
        cfg.sizeMinusOne = 4'h7;
        cfg.prescaleDivisor = 8'h02;
        {arst_n, txWrite, rxRead, intMask, statusClear, txData} = '0;
        repeat (4) @(negedge clk);
        arst_n = 1'h1;
        step(2);
        t_reset();
        t_single();
        t_fill();
        t_pulse();
        t_idle();
        close_out();
    end
endmodule : sync_serial_port_core_tb

`default_nettype wire
